// *** rtl/pgs_status_regs.sv ***
// power-good status, mask and undervoltage flag registers behind a serial bus slave
`timescale 1ns/1ns
module pgs_status_regs
   import pgs_pkg::*;
#(
   parameter logic [6:0] DEVICE_ADDR = 7'h2A,                // bus address, value arbitrary
   parameter int         UVD_SHORT_CYC = PGS_UVD_SHORT_CYC,  // short delay cycles
   parameter int         UVD_LONG_CYC  = PGS_UVD_LONG_CYC    // long delay cycles
) (
   input  wire logic       core_clk_i,                       // core clock, 20 MHz
   input  wire logic       resetn_i,                         // synchronous reset, active low
   input  wire logic       scl_i,                            // bus clock pin
   input  wire logic       sda_i,                            // bus data pin level
   output logic            sda_o,                            // bus data drive value
   output logic            sda_oe_o,                         // bus data drive enable
   input  wire logic       enable_pin_i,                     // enable pin level
   input  wire logic [6:0] channel_good_i,                   // per-channel power good
   input  wire logic [6:0] channel_uv_i,                     // per-channel undervoltage detect
   input  wire logic [6:0] channel_on_i,                     // per-channel enabled, same clock
   input  wire logic [1:0] undervoltage_delay_select_i,      // delay code, same clock
   input  wire logic [6:0] fuse_mask_i,                      // fused mask default
   output logic            fault_o                           // fault pin, high on unmasked bad channel
);

   // ================================================================
   // synchronised pins
   logic       scl_s;                                        // filtered bus clock
   logic       sda_s;                                        // filtered bus data
   logic       en_s;                                         // filtered enable level
   logic [6:0] good_s;                                       // filtered power good
   logic [6:0] uv_s;                                         // filtered undervoltage
   logic       scl_d;                                        // bus clock last cycle
   logic       sda_d;                                        // bus data last cycle

   pgs_sync #(
      .WIDTH (2),
      .INIT  (2'h3)
   ) u_bus_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .async_i    ({scl_i, sda_i}),
      .sync_o     ({scl_s, sda_s})
   );

   pgs_sync #(
      .WIDTH (15),
      .INIT  (15'h0000)
   ) u_pin_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .async_i    ({enable_pin_i, channel_good_i, channel_uv_i}),
      .sync_o     ({en_s, good_s, uv_s})
   );

   // ================================================================
   // registers
   logic [6:0] status_good;                                  // power good bits
   logic       status_en;                                    // enable level bit
   logic [6:0] power_good_mask;                              // fault mask
   logic       fuse_loaded;                                  // fuse defaults taken
   logic [6:0] undervoltage_flags;                           // sticky flags
   logic [6:0] uv_armed;                                     // per-channel detection window open

   // ================================================================
   // bus slave state
   pgs_state_e state;                                        // slave state
   logic [3:0] bit_cnt;                                      // bits of current byte
   logic [7:0] shreg;                                        // byte shift register
   logic [7:0] ptr;                                          // register pointer
   logic       rd_mode;                                      // address byte asked for read
   logic       host_ack;                                     // host acked last read byte
   logic       wr_stb;                                       // one-cycle register write
   logic [7:0] wr_addr;                                      // write target
   logic [7:0] wr_data;                                      // write value
   logic [7:0] rd_value;                                     // read mux output
   logic       scl_rise;                                     // bus clock rising
   logic       scl_fall;                                     // bus clock falling
   logic       bus_start;                                    // start or repeated start
   logic       bus_stop;                                     // stop condition
   logic [7:0] rx_byte;                                      // byte completed at this rise

   // ================================================================
   // edge history of bus lines
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise  = scl_s && !scl_d;
   assign scl_fall  = !scl_s && scl_d;
   assign bus_start = scl_s && scl_d && sda_d && !sda_s;
   assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;
   assign rx_byte   = {shreg[6:0], sda_s};

   // ================================================================
   // read multiplexer, reserved bits and unmapped offsets read zero
   always_comb begin
      unique case (ptr)
         PGS_OFS_STATUS: rd_value = {status_en, status_good};
         PGS_OFS_MASK:   rd_value = {1'b0, power_good_mask};
         PGS_OFS_UVFLAG: rd_value = {1'b0, undervoltage_flags};
         default:        rd_value = PGS_BYTE_ZERO;
      endcase
   end

   // ================================================================
   // bus slave sequencer
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state    <= PGS_ST_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         ptr      <= 8'h00;
         rd_mode  <= 1'b0;
         host_ack <= 1'b0;
      end else if (bus_start) begin
         // start from any state restarts address reception
         state   <= PGS_ST_ADDR;
         bit_cnt <= 4'h0;
      end else if (bus_stop) begin
         state <= PGS_ST_IDLE;
      end else begin
         unique case (state)
            PGS_ST_IDLE: begin
               bit_cnt <= 4'h0;
            end
            PGS_ST_ADDR, PGS_ST_PTR, PGS_ST_WR: begin
               // shift data in on rise, act on fall after eighth bit
               if (scl_rise && bit_cnt < 4'h8) begin
                  shreg   <= rx_byte;
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (state == PGS_ST_ADDR) begin
                     if (shreg[7:1] == DEVICE_ADDR) begin
                        rd_mode <= shreg[0];
                        state   <= PGS_ST_ACK_ADR;
                     end else begin
                        state <= PGS_ST_IDLE;
                     end
                  end else if (state == PGS_ST_PTR) begin
                     ptr   <= shreg;
                     state <= PGS_ST_ACK_PTR;
                  end else begin
                     ptr   <= ptr + 8'h01;
                     state <= PGS_ST_ACK_WR;
                  end
               end
            end
            PGS_ST_ACK_ADR: begin
               // leave acknowledge on the fall that ends it
               if (scl_fall) begin
                  if (rd_mode) begin
                     shreg <= rd_value;
                     ptr   <= ptr + 8'h01;
                     state <= PGS_ST_RD;
                  end else begin
                     state <= PGS_ST_PTR;
                  end
               end
            end
            PGS_ST_ACK_PTR, PGS_ST_ACK_WR: begin
               if (scl_fall) begin
                  state <= PGS_ST_WR;
               end
            end
            PGS_ST_RD: begin
               // bit 7 of shreg is on the line; shift after each fall but the eighth
               if (scl_fall) begin
                  if (bit_cnt == 4'h7) begin
                     bit_cnt <= 4'h0;
                     state   <= PGS_ST_ACK_RD;
                  end else begin
                     shreg   <= {shreg[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            PGS_ST_ACK_RD: begin
               // host low acknowledge asks for the next byte
               if (scl_rise) begin
                  host_ack <= !sda_s;
               end else if (scl_fall) begin
                  if (host_ack) begin
                     shreg <= rd_value;
                     ptr   <= ptr + 8'h01;
                     state <= PGS_ST_RD;
                  end else begin
                     state <= PGS_ST_IDLE;
                  end
               end
            end
            default: begin
               state <= PGS_ST_IDLE;
            end
         endcase
      end
   end

   // ================================================================
   // write strobe at the end of a data byte
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         wr_stb  <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_stb  <= (state == PGS_ST_WR) && scl_fall && (bit_cnt == 4'h8) && !bus_start && !bus_stop;
         wr_addr <= ptr;
         wr_data <= shreg;
      end
   end

   // ================================================================
   // data line drive: acknowledge low, read data low for zero bits
   assign sda_o = 1'b0;

   always_comb begin
      unique case (state)
         PGS_ST_ACK_ADR, PGS_ST_ACK_PTR, PGS_ST_ACK_WR: sda_oe_o = 1'b1;
         PGS_ST_RD:                                     sda_oe_o = !shreg[7];
         default:                                       sda_oe_o = 1'b0;
      endcase
   end

   // ================================================================
   // live status, read-only, zero from reset
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         status_good <= PGS_CH_RST;
         status_en   <= PGS_EN_RST;
      end else begin
         status_good <= good_s;
         status_en   <= en_s;
      end
   end

   // ================================================================
   // mask register, fused default taken at the first edge after reset
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         power_good_mask <= PGS_CH_RST;
         fuse_loaded     <= 1'b0;
      end else if (!fuse_loaded) begin
         power_good_mask <= fuse_mask_i;
         fuse_loaded     <= 1'b1;
      end else if (wr_stb && wr_addr == PGS_OFS_MASK) begin
         power_good_mask <= wr_data[6:0];
      end
   end

   // ================================================================
   // detection delay timer per channel
   for (genvar ch = 0; ch < PGS_NUM_CH; ch++) begin : g_uvd
      pgs_uv_delay #(
         .CNT_W     (PGS_UVD_CNT_W),
         .SHORT_CYC (UVD_SHORT_CYC),
         .LONG_CYC  (UVD_LONG_CYC)
      ) u_uvd (
         .core_clk_i (core_clk_i),
         .resetn_i   (resetn_i),
         .start_i    (channel_on_i[ch]),
         .sel_i      (undervoltage_delay_select_i),
         .armed_o    (uv_armed[ch])
      );
   end

   // ================================================================
   // sticky undervoltage flags, write one clears, set wins
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         undervoltage_flags <= PGS_CH_RST;
      end else if (wr_stb && wr_addr == PGS_OFS_UVFLAG) begin
         undervoltage_flags <= (undervoltage_flags & ~wr_data[6:0])
                               | (uv_s & uv_armed);
      end else begin
         undervoltage_flags <= undervoltage_flags | (uv_s & uv_armed);
      end
   end

   // ================================================================
   // fault pin from unmasked channels whose power is not good
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         fault_o <= 1'b0;
      end else begin
         fault_o <= fuse_loaded && |(~status_good & ~power_good_mask);
      end
   end

endmodule

// *** inc/pgs_pkg.sv ***
// constants shared by the power-good / undervoltage status register block
// ================================================================
// Operation
// - enable pin level shown in status bit 7
// - channel 1..7 power good in bits 0..6
// - status reads zero after reset, read-only
// - unmasked channel power good drives fault pin
// - masked channel excluded from fault, still reported
// - mask reset value loaded from fuses; read/write
// - undervoltage sets sticky per-channel flag bits 0..6
// - writing one clears an undervoltage flag
// - undervoltage flags read zero after reset
// - detection delay 0/21/45 ms, or disabled
package pgs_pkg;

   // ================================================================
   // register map (byte offsets on the serial configuration bus)
   localparam logic [7:0] PGS_OFS_STATUS = 8'h18;    // power_good_status
   localparam logic [7:0] PGS_OFS_MASK   = 8'h19;    // power_good_mask
   localparam logic [7:0] PGS_OFS_UVFLAG = 8'h1A;    // undervoltage_flags

   // ================================================================
   // field layout
   localparam int         PGS_NUM_CH     = 7;        // channels 1..7 on bits 0..6
   localparam int         PGS_EN_BIT     = 7;        // enable pin level bit
   localparam logic [6:0] PGS_CH_RST     = 7'h00;    // reset value of per-channel fields
   localparam logic       PGS_EN_RST     = 1'b0;     // reset value of enable level bit
   localparam logic [7:0] PGS_BYTE_ZERO  = 8'h00;    // unmapped / reserved read value

   // ================================================================
   // undervoltage delay select codes
   localparam logic [1:0] PGS_UVD_0MS    = 2'h0;     // detect at once
   localparam logic [1:0] PGS_UVD_21MS   = 2'h1;     // short delay
   localparam logic [1:0] PGS_UVD_45MS   = 2'h2;     // long delay
   localparam logic [1:0] PGS_UVD_OFF    = 2'h3;     // protection disabled

   // ================================================================
   // timing
   localparam int         PGS_CLK_KHZ    = 20000;    // core clock 20 MHz
   localparam int         PGS_UVD_SHORT_MS = 21;     // short delay in ms
   localparam int         PGS_UVD_LONG_MS  = 45;     // long delay in ms
   localparam int         PGS_UVD_SHORT_CYC = PGS_UVD_SHORT_MS * PGS_CLK_KHZ;  // 420000 cycles
   localparam int         PGS_UVD_LONG_CYC  = PGS_UVD_LONG_MS * PGS_CLK_KHZ;   // 900000 cycles
   localparam int         PGS_UVD_CNT_W  = 20;       // delay counter width

   // ================================================================
   // serial bus slave state machine
   typedef enum logic [3:0] {
      PGS_ST_IDLE    = 4'h0,   // waiting for start
      PGS_ST_ADDR    = 4'h1,   // receiving device address
      PGS_ST_ACK_ADR = 4'h2,   // acknowledging address
      PGS_ST_PTR     = 4'h3,   // receiving register pointer
      PGS_ST_ACK_PTR = 4'h4,   // acknowledging pointer
      PGS_ST_WR      = 4'h5,   // receiving write data
      PGS_ST_ACK_WR  = 4'h6,   // acknowledging write data
      PGS_ST_RD      = 4'h7,   // sending read data
      PGS_ST_ACK_RD  = 4'h8    // sampling host acknowledge
   } pgs_state_e;

endpackage

// *** rtl/pgs_sync.sv ***
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
module pgs_sync
   import pgs_pkg::*;
#(
   parameter int               WIDTH = 1,          // number of bits
   parameter logic [WIDTH-1:0] INIT  = '0          // value during reset
) (
   input  wire logic             core_clk_i,       // core clock
   input  wire logic             resetn_i,         // synchronous reset, active low
   input  wire logic [WIDTH-1:0] async_i,          // raw pin level
   output logic      [WIDTH-1:0] sync_o            // filtered level
);

   logic [WIDTH-1:0] meta;                          // first stage, read only by second
   logic [WIDTH-1:0] stage2;                        // second stage
   logic [WIDTH-1:0] stage3;                        // third stage

   // ================================================================
   // shift chain
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         meta   <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         meta   <= async_i;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // ================================================================
   // a bit changes only once stages two and three agree
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         sync_o <= INIT;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_o[i] <= stage3[i];
            end
         end
      end
   end

endmodule

// *** rtl/pgs_uv_delay.sv ***
// per-channel undervoltage detection delay timer
`timescale 1ns/1ns
module pgs_uv_delay
   import pgs_pkg::*;
#(
   parameter int CNT_W     = PGS_UVD_CNT_W,        // counter width
   parameter int SHORT_CYC = PGS_UVD_SHORT_CYC,    // cycles for short delay
   parameter int LONG_CYC  = PGS_UVD_LONG_CYC      // cycles for long delay
) (
   input  wire logic       core_clk_i,             // core clock
   input  wire logic       resetn_i,               // synchronous reset, active low
   input  wire logic       start_i,                // channel enabled, delay runs while high
   input  wire logic [1:0] sel_i,                  // undervoltage delay select code
   output logic            armed_o                 // detection allowed
);

   logic [CNT_W-1:0] cnt;                           // cycles since channel enable
   logic [CNT_W-1:0] target;                        // cycles required by selection

   // ================================================================
   // refuse counts the counter cannot reach
   if (SHORT_CYC > LONG_CYC || LONG_CYC >= (2 ** CNT_W) - 1) begin : g_chk
      $error("pgs_uv_delay: delay counts do not fit counter");
   end

   // ================================================================
   // target count from delay select
   always_comb begin
      unique case (sel_i)
         PGS_UVD_0MS:  target = '0;
         PGS_UVD_21MS: target = CNT_W'(SHORT_CYC);
         PGS_UVD_45MS: target = CNT_W'(LONG_CYC);
         PGS_UVD_OFF:  target = '0;
      endcase
   end

   // ================================================================
   // count while enabled, saturate at target
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cnt <= '0;
      end else if (!start_i) begin
         cnt <= '0;
      end else if (cnt < target) begin
         cnt <= cnt + CNT_W'(1);
      end
   end

   // ================================================================
   // armed once delay elapsed, never when disabled
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         armed_o <= 1'b0;
      end else begin
         armed_o <= start_i && (sel_i != PGS_UVD_OFF) && (cnt >= target);
      end
   end

endmodule

// *** sim/pgs_checker.sv ***
// assertion checker for the status register block, bound to its ports
`timescale 1ns/1ns
module pgs_checker
   import pgs_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       resetn_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic [6:0] channel_good_i,
   input wire logic       fault_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   logic [3:0] good_cnt;   // cycles with every channel good
   // count how long all channels have been good
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || channel_good_i != 7'h7F) begin
         good_cnt <= 4'h0;
      end else if (good_cnt != 4'hF) begin
         good_cnt <= good_cnt + 4'h1;
      end
   end
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   a_fault_in_reset: assert property (!resetn_i |=> !fault_o) else $error("fault set in reset");
   a_oe_in_reset: assert property (!resetn_i |=> !sda_oe_o) else $error("bus driven in reset");
   a_fault_release: assert property ($rose(resetn_i) |-> !fault_o ##1 !fault_o) else $error("early fault");
   a_good_no_fault: assert property (disable iff (!resetn_i) good_cnt == 4'hF |-> !fault_o)
      else $error("fault while all good");
   a_sda_open_drain: assert property (sda_o == 1'b0) else $error("data driven high");
   a_oe_scl_low: assert property (disable iff (!resetn_i) $changed(sda_oe_o) |-> !scl_i)
      else $error("data moved while clock high");
   a_stop_release: assert property (disable iff (!resetn_i) s_stop |-> ##[1:8] !sda_oe_o)
      else $error("bus held after stop");
   a_start_quiet: assert property (disable iff (!resetn_i) s_start |-> !sda_oe_o [*8])
      else $error("bus driven after start");
endmodule
bind pgs_status_regs pgs_checker u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .channel_good_i(channel_good_i), .fault_o(fault_o));

// *** sim/pgs_host_model.sv ***
// serial bus host model: clock and open-drain data
`timescale 1ns/1ns
module pgs_host_model #(
   parameter int         HALF = 6,        // core cycles per clock phase step
   parameter logic [6:0] ADDR = 7'h2A     // device address, value arbitrary
) (
   input  wire logic core_clk_i,
   input  wire logic sda_i,               // resolved data line
   output logic      scl_o,               // bus clock, idles high
   output logic      sda_low_o            // high pulls data low
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // move clock and data after a wait, one of them at a time
   task automatic step(input logic c, input logic d);
      repeat (HALF) @(posedge core_clk_i);
      scl_o <= c;
      sda_low_o <= d;
   endtask
   task automatic start();
      step(1'b0, sda_low_o);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic stop();
      step(1'b0, sda_low_o);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   // one bit, sampled halfway through the high phase
   task automatic put_bit(input logic b, output logic r);
      step(1'b0, sda_low_o);
      step(1'b0, !b);
      step(1'b1, !b);
      repeat (HALF) @(posedge core_clk_i);
      r = sda_i;
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], r);
      end
      put_bit(1'b1, r);
      ack = !r;
   endtask
   // write one register; flags are cleared this way too
   task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      put_byte({ADDR, 1'b0}, a0);
      put_byte(p, a1);
      put_byte(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   // read one register, ending with no acknowledge
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic a, r;
      start();
      put_byte({ADDR, 1'b0}, a);
      put_byte(p, a);
      start();
      put_byte({ADDR, 1'b1}, a);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      put_bit(1'b1, r);
      stop();
   endtask
endmodule

// *** sim/pgs_status_regs_tb_top.sv ***
// self-checking bench for the status register block
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); end end
module pgs_status_regs_tb_top
   import pgs_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        en = 1'b0;
   logic [6:0]  good = 7'h00;
   logic [6:0]  uv = 7'h00;
   logic [6:0]  on = 7'h00;
   logic [6:0]  fuse = 7'h00;
   logic [1:0]  dly = 2'h0;
   wire         scl, host_low, sda_oe, fault;
   wire         sda = !(host_low | sda_oe);   // pull-up on the data line
   int          errors = 0;
   int          cmp_count = 0;
   logic [31:0] seed = 32'h2A3D8528;
   logic [7:0]  rv;
   logic        ok;
   always #25 clk = !clk;
   pgs_status_regs #(.UVD_SHORT_CYC(3000), .UVD_LONG_CYC(6000)) u_dut (.core_clk_i(clk), .resetn_i(resetn),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .enable_pin_i(en), .channel_good_i(good),
      .channel_uv_i(uv), .channel_on_i(on), .undervoltage_delay_select_i(dly), .fuse_mask_i(fuse),
      .fault_o(fault));
   pgs_host_model u_host (.core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // flags expected at read phase ph (0: at once, 1: past short, 2: past long)
   function logic [7:0] uv_exp(input logic [1:0] c, input int ph, input logic [6:0] u);
      return (c != PGS_UVD_OFF && ph >= c) ? {1'b0, u} : PGS_BYTE_ZERO;
   endfunction
   function logic fault_exp(input logic [6:0] g, input logic [6:0] m);
      return |(~g & ~m);
   endfunction
   task automatic rd_chk(input logic [7:0] p, input logic [7:0] ex, input string nm);
      u_host.rd(p, rv);
      `CHK(nm, ex, rv)
   endtask
   initial begin
      logic [7:0] m;
      logic [6:0] p;
      logic [31:0] rnd;   // random word, kept apart from read data
      rnd = xs();
      fuse <= rnd[6:0];
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (20) @(posedge clk);
      rd_chk(PGS_OFS_STATUS, PGS_BYTE_ZERO, "status");
      rd_chk(PGS_OFS_MASK, {1'b0, fuse}, "mask_fuse");
      rd_chk(PGS_OFS_UVFLAG, PGS_BYTE_ZERO, "uv_reset");
      rd_chk(8'h3C, PGS_BYTE_ZERO, "unmapped");
      `CHK("fault_fuse", fault_exp(good, fuse), fault)
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         rnd = xs();
         en <= rnd[31];
         good <= (i == 0) ? 7'h7F : rnd[30:24];
         m = (i == 1) ? 8'hFF : rnd[7:0];
         u_host.wr(PGS_OFS_MASK, m, ok);
         `CHK("ack", 1'b1, ok)
         u_host.wr(PGS_OFS_STATUS, rnd[15:8], ok);
         `CHK("ack_ro", 1'b1, ok)
         rd_chk(PGS_OFS_STATUS, {en, good}, "status");
         rd_chk(PGS_OFS_MASK, {1'b0, m[6:0]}, "mask");
         `CHK("fault", fault_exp(good, m[6:0]), fault)
      end
      $display("test status_mask done");
      for (int c = 0; c < 4; c++) begin
         rnd = xs();
         p = rnd[6:0] | 7'h01;
         dly <= c[1:0];
         uv <= p;
         @(posedge clk);
         on <= 7'h7F;
         for (int ph = 0; ph < 3; ph++) begin
            if (ph > 0) begin
               repeat (2500) @(posedge clk);
            end
            rd_chk(PGS_OFS_UVFLAG, uv_exp(c[1:0], ph, p), "uv_flag");
         end
         u_host.wr(PGS_OFS_UVFLAG, 8'hFF, ok);
         rd_chk(PGS_OFS_UVFLAG, uv_exp(c[1:0], 2, p), "uv_held");
         uv <= 7'h00;
         u_host.wr(PGS_OFS_UVFLAG, {1'b1, rnd[14:8]}, ok);
         rd_chk(PGS_OFS_UVFLAG, uv_exp(c[1:0], 2, p) & {1'b0, ~rnd[14:8]}, "uv_w1c");
         u_host.wr(PGS_OFS_UVFLAG, 8'hFF, ok);
         rd_chk(PGS_OFS_UVFLAG, PGS_BYTE_ZERO, "uv_clr");
         on <= 7'h00;
      end
      $display("test undervoltage done");
      complete_run();
   end
   // watchdog cuts a hang short
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      complete_run();
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
endmodule
